// ===== scd_regs.svh
// constants of the 8b/10b serdes datapath: register map, codes, counts
// assumes one bit time per pclk cycle, 20 bit times per word
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH
`define SCD_WORD_BITS 20
`define SCD_RX_LAT_MIN 76
`define SCD_RX_LAT_MAX 107
`define SCD_PHASE_LAST 5'h13
`define SCD_PHASE_HALF 5'h0A
`define SCD_COMMA 7'h7C
`define SCD_PRBS_SEED 7'h7F
`define SCD_K_ERR 8'h00
`define SCD_K_LOS 8'hFF
`define SCD_K28_6B 6'h0F
`define SCD_LOS_BITS 8'h14
`define SCD_REG_CTRL 12'h000
`define SCD_REG_STAT 12'h004
`define SCD_CTRL_PRBS 0
`define SCD_STAT_ALIGNED 0
`define SCD_STAT_LOS 1
`define SCD_STAT_PRBS_ERR 2
`define SCD_STAT_DEC_ERR 3
`endif

// ===== scd_pkg.sv
// shared types of the 8b/10b serdes datapath
// assumes nothing of its surroundings
package scd_pkg;
   typedef logic [9:0] scd_sym_t;
   typedef logic [19:0] scd_word_t;
   typedef logic [4:0] scd_phase_t;
   typedef logic [17:0] scd_rxw_t;
endpackage

// ===== scd_codec.sv
// one lane of 8b/10b: combinational encoder and decoder with disparity in/out
// assumes symbol bit 0 is the first bit on the line (bit a)
`timescale 1ns/1ps
`include "scd_regs.svh"
module scd_codec
   import scd_pkg::*;
(
   input wire logic [7:0] enc_byte, // byte to encode
   input wire logic enc_k, // encode as control character
   input wire logic enc_rd_in, // running disparity in, 1 = positive
   output scd_sym_t enc_code, // encoded symbol
   output logic enc_rd_out, // running disparity out
   input wire scd_sym_t dec_code, // symbol to decode
   input wire logic dec_rd_in, // running disparity in
   output logic [7:0] dec_byte, // decoded byte or error code
   output logic dec_k, // control character or error
   output logic dec_err, // symbol invalid
   output logic dec_rd_out // running disparity out
);
   // 6b codes, written a first, negative disparity column
   function automatic logic [5:0] tbl6(input logic [4:0] x);
      case (x)
         5'h00: tbl6 = 6'h27;  5'h01: tbl6 = 6'h1D;  5'h02: tbl6 = 6'h2D;  5'h03: tbl6 = 6'h31;
         5'h04: tbl6 = 6'h35;  5'h05: tbl6 = 6'h29;  5'h06: tbl6 = 6'h19;  5'h07: tbl6 = 6'h38;
         5'h08: tbl6 = 6'h39;  5'h09: tbl6 = 6'h25;  5'h0A: tbl6 = 6'h15;  5'h0B: tbl6 = 6'h34;
         5'h0C: tbl6 = 6'h0D;  5'h0D: tbl6 = 6'h2C;  5'h0E: tbl6 = 6'h1C;  5'h0F: tbl6 = 6'h17;
         5'h10: tbl6 = 6'h1B;  5'h11: tbl6 = 6'h23;  5'h12: tbl6 = 6'h13;  5'h13: tbl6 = 6'h32;
         5'h14: tbl6 = 6'h0B;  5'h15: tbl6 = 6'h2A;  5'h16: tbl6 = 6'h1A;  5'h17: tbl6 = 6'h3A;
         5'h18: tbl6 = 6'h33;  5'h19: tbl6 = 6'h26;  5'h1A: tbl6 = 6'h16;  5'h1B: tbl6 = 6'h36;
         5'h1C: tbl6 = 6'h0E;  5'h1D: tbl6 = 6'h2E;  5'h1E: tbl6 = 6'h1E;
         default: tbl6 = 6'h2B;
      endcase
   endfunction

   function automatic logic [3:0] tbl4(input logic [2:0] y);
      case (y)
         3'h0: tbl4 = 4'hB;  3'h1: tbl4 = 4'h9;  3'h2: tbl4 = 4'h5;  3'h3: tbl4 = 4'hC;
         3'h4: tbl4 = 4'hD;  3'h5: tbl4 = 4'hA;  3'h6: tbl4 = 4'h6;
         default: tbl4 = 4'hE;
      endcase
   endfunction

   // data values that take the alternate x.7 code at each disparity
   function automatic logic alt7_ok(input logic [4:0] x, input logic rd);
      alt7_ok = rd ? (x == 5'h0B || x == 5'h0D || x == 5'h0E)
                   : (x == 5'h11 || x == 5'h12 || x == 5'h14);
   endfunction

   function automatic logic k7_ok(input logic [4:0] x);
      k7_ok = x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E;
   endfunction

   always_comb begin
      logic [5:0] c6;
      logic [3:0] c4;
      logic k28, unb6, unb4, rd_mid, a7;
      k28 = enc_k && enc_byte[4:0] == 5'h1C;
      c6 = k28 ? `SCD_K28_6B : tbl6(enc_byte[4:0]);
      unb6 = $countones(c6) != 3;
      if (enc_rd_in && (unb6 || (enc_byte[4:0] == 5'h07 && !k28))) c6 = ~c6;
      rd_mid = unb6 ? !enc_rd_in : enc_rd_in;
      a7 = enc_byte[7:5] == 3'h7 && (enc_k || alt7_ok(enc_byte[4:0], rd_mid));
      c4 = a7 ? 4'h7 : tbl4(enc_byte[7:5]);
      unb4 = $countones(c4) != 2;
      if (rd_mid && (unb4 || enc_byte[7:5] == 3'h3)) c4 = ~c4;
      // comma family flips balanced tails at negative disparity
      else if (k28 && !unb4 && enc_byte[7:5] != 3'h3 && !rd_mid) c4 = ~c4;
      enc_code = {<<{c6, c4}};
      enc_rd_out = unb4 ? !rd_mid : rd_mid;
   end

   always_comb begin
      logic [9:0] w;
      logic [5:0] t6;
      logic [3:0] t4, d4;
      logic [4:0] x;
      logic [2:0] y;
      logic hit6, hit4, k28, a7, rd_mid;
      w = {<<{dec_code}};
      t6 = '0;
      t4 = '0;
      x = '0;
      y = '0;
      hit6 = 1'b0;
      hit4 = 1'b0;
      a7 = 1'b0;
      // expected codes depend on disparity, so a wrong-disparity symbol misses
      k28 = w[9:4] == (dec_rd_in ? ~`SCD_K28_6B : `SCD_K28_6B);
      for (int i = 0; i < 32; i++) begin
         t6 = tbl6(5'(i));
         if (dec_rd_in && ($countones(t6) != 3 || i == 7)) t6 = ~t6;
         if (w[9:4] == t6) begin
            hit6 = 1'b1;
            x = 5'(i);
         end
      end
      if (k28) begin
         hit6 = 1'b1;
         x = 5'h1C;
      end
      rd_mid = $countones(w[9:4]) == 4 ? 1'b1 : $countones(w[9:4]) == 2 ? 1'b0 : dec_rd_in;
      d4 = w[3:0];
      if (k28 && !rd_mid && $countones(d4) == 2 && d4 != 4'hC && d4 != 4'h3) d4 = ~d4;
      for (int j = 0; j < 8; j++) begin
         t4 = tbl4(3'(j));
         if (rd_mid && ($countones(t4) != 2 || j == 3)) t4 = ~t4;
         if (d4 == t4) begin
            hit4 = 1'b1;
            y = 3'(j);
         end
      end
      if (w[3:0] == (rd_mid ? 4'h8 : 4'h7)) begin
         hit4 = 1'b1;
         y = 3'h7;
         a7 = 1'b1;
      end
      dec_k = k28 || (a7 && k7_ok(x));
      dec_err = !hit6 || !hit4 || (a7 && !dec_k && !alt7_ok(x, rd_mid));
      dec_byte = dec_err ? `SCD_K_ERR : {y, x};
      dec_k = dec_k || dec_err;
      dec_rd_out = $countones(w[3:0]) == 3 ? 1'b1 : $countones(w[3:0]) == 1 ? 1'b0 : rd_mid;
   end
endmodule // scd_codec

// ===== scd_datapath.sv
// 16-bit 8b/10b serdes datapath: encode, serialize, deserialize, align, decode
// assumes one line bit per pclk; serial inputs synchronous to pclk; APB3 slave
// How it works
// - split word into two bytes, disparity chained low to high
// - k flag per byte selects control character
// - encoders keep running disparity for dc balance
// - prbs mode loads 2^7-1 sequence into serializer
// - prbs mode ignores parallel data and flags
// - 20-bit word shifted out bit 0 first
// - align to two symbols, decode, word out
// - receive outputs valid on word clock rise
// - receive latency 76 to 107 bits, fixed
// - only the 0011111 comma aligns
// - comma symbol lands in the low byte
// - receive k flags mark control characters
// - only K28.x and four x.7 controls valid
// - bad byte becomes K0.0, other byte untouched
// - lost signal gives K31.7 on both bytes
// - word clock is bit rate/20, low in reset
// - transmit word taken on word clock rise
// - prbs mode checks receive, low-byte flag shows pass
`timescale 1ns/1ps
`include "scd_regs.svh"
module scd_datapath
   import scd_pkg::*;
#(
   parameter int RX_PIPE_WORDS = (`SCD_RX_LAT_MIN + `SCD_WORD_BITS - 1) / `SCD_WORD_BITS - 1,
   parameter logic [7:0] LOS_BITS = `SCD_LOS_BITS
)(
   input wire logic pclk, // bit clock, 40 MHz
   input wire logic presetn, // async reset, active low
   input wire logic [11:0] paddr, // apb byte address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [15:0] tx_data, // transmit word
   input wire logic tx_k_lo, // low byte is control
   input wire logic tx_k_hi, // high byte is control
   output logic tx_word_clock, // transmit word clock
   output logic serial_out_p, // serial line, true
   output logic serial_out_n, // serial line, complement
   input wire logic serial_in_p, // serial input, true
   input wire logic serial_in_n, // serial input, complement
   output logic [15:0] rx_data, // received word
   output logic rx_k_lo, // low byte control, or item_a
   output logic rx_k_hi, // high byte control
   output logic rx_word_clock // recovered word clock
);
   localparam int LAST = RX_PIPE_WORDS - 1;

   function automatic logic reg_mapped(input logic [11:0] a);
      reg_mapped = a == `SCD_REG_CTRL || a == `SCD_REG_STAT;
   endfunction

   logic prbs_enable, aligned, los, prbs_err_st, dec_err_st;
   scd_phase_t tx_phase, next_tx_phase, rx_phase, next_rx_phase;
   logic tx_ld, tx_rd, rx_rd, rx_cap, comma, bit_err, word_err, item_a;
   logic [15:0] tx_q;
   logic [1:0] tx_kq;
   scd_word_t tx_word, prbs_word, ser, rx_sr;
   logic [6:0] prbs_state, next_prbs_state;
   logic [7:0] los_cnt;
   // nets, since each bit has its own driver: lane ports and the chain entry
   wire logic [2:0] enc_rd, dec_rd;
   scd_sym_t enc_code [2];
   logic [7:0] dec_byte [2];
   wire logic [1:0] dec_k, dec_err;
   scd_rxw_t rx_pipe [RX_PIPE_WORDS];

   // two lanes, disparity chained low then high
   generate
      for (genvar g = 0; g < 2; g++) begin : g_lane
         scd_codec u_codec (
            .enc_byte(tx_q[8*g +: 8]),
            .enc_k(tx_kq[g]),
            .enc_rd_in(enc_rd[g]),
            .enc_code(enc_code[g]),
            .enc_rd_out(enc_rd[g+1]),
            .dec_code(rx_sr[10*g +: 10]),
            .dec_rd_in(dec_rd[g]),
            .dec_byte(dec_byte[g]),
            .dec_k(dec_k[g]),
            .dec_err(dec_err[g]),
            .dec_rd_out(dec_rd[g+1])
         );
      end
   endgenerate
   assign enc_rd[0] = tx_rd;
   assign dec_rd[0] = rx_rd;

   // transmit word timing
   assign tx_ld = tx_phase == `SCD_PHASE_LAST;
   assign next_tx_phase = tx_ld ? '0 : tx_phase + 5'h01;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_phase <= `SCD_PHASE_LAST;
         tx_word_clock <= 1'b0;
      end else begin
         tx_phase <= next_tx_phase;
         tx_word_clock <= next_tx_phase < `SCD_PHASE_HALF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_q <= '0;
         tx_kq <= '0;
      end else if (tx_ld) begin
         tx_q <= tx_data;
         tx_kq <= {tx_k_hi, tx_k_lo};
      end
   end

   always_comb begin
      logic [6:0] s;
      s = prbs_state;
      prbs_word = '0;
      for (int i = 0; i < `SCD_WORD_BITS; i++) begin
         prbs_word[i] = s[6] ^ s[5];
         s = {s[5:0], prbs_word[i]};
      end
      next_prbs_state = s;
   end

   // parallel input bypassed in prbs mode
   assign tx_word = prbs_enable ? prbs_word : {enc_code[1], enc_code[0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prbs_state <= `SCD_PRBS_SEED;
         tx_rd <= 1'b0;
      end else if (tx_ld) begin
         if (prbs_enable) prbs_state <= next_prbs_state;
         else tx_rd <= enc_rd[2];
      end
   end

   // shift out bit 0 first, one bit per clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ser <= '0;
         serial_out_p <= 1'b0;
         serial_out_n <= 1'b1;
      end else if (tx_ld) begin
         ser <= {1'b0, tx_word[19:1]};
         serial_out_p <= tx_word[0];
         serial_out_n <= !tx_word[0];
      end else begin
         ser <= {1'b0, ser[19:1]};
         serial_out_p <= ser[0];
         serial_out_n <= !ser[0];
      end
   end

   // input already retimed to pclk; equal legs count as no signal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sr <= '0;
         los_cnt <= '0;
         los <= 1'b1;
      end else begin
         rx_sr <= {serial_in_p, rx_sr[19:1]};
         if (serial_in_p != serial_in_n) los_cnt <= '0;
         else if (los_cnt != LOS_BITS) los_cnt <= los_cnt + 8'h01;
         los <= los_cnt == LOS_BITS;
      end
   end

   // one comma polarity only, oldest bits first
   assign comma = rx_sr[6:0] == `SCD_COMMA && !los;
   // boundary moves only when a comma is seen elsewhere
   assign rx_cap = rx_phase == `SCD_PHASE_LAST || comma;
   assign next_rx_phase = rx_cap ? '0 : rx_phase + 5'h01;

   // word clock = bits/20, low in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_phase <= '0;
         rx_word_clock <= 1'b0;
         aligned <= 1'b0;
      end else begin
         rx_phase <= next_rx_phase;
         rx_word_clock <= next_rx_phase >= `SCD_PHASE_HALF;
         if (comma) aligned <= 1'b1;
         else if (los) aligned <= 1'b0;
      end
   end

   assign bit_err = rx_sr[19] != (rx_sr[13] ^ rx_sr[12]);
   assign item_a = !(word_err || bit_err || los);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_rd <= 1'b0;
         word_err <= 1'b0;
         for (int i = 0; i < RX_PIPE_WORDS; i++) rx_pipe[i] <= '0;
      end else begin
         word_err <= rx_cap ? 1'b0 : word_err || bit_err;
         if (rx_cap) begin
            rx_rd <= dec_rd[2];
            // lost signal forces the invalid control on both bytes
            if (los) rx_pipe[0] <= {2'b11, `SCD_K_LOS, `SCD_K_LOS};
            // comma symbol in low byte, per-byte flags
            else rx_pipe[0] <= {dec_k[1], dec_k[0], dec_byte[1], dec_byte[0]};
            // fixed pipe of whole words sets latency
            for (int i = 1; i < RX_PIPE_WORDS; i++) rx_pipe[i] <= rx_pipe[i-1];
         end
      end
   end

   // outputs change while word clock is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data <= '0;
         rx_k_lo <= 1'b0;
         rx_k_hi <= 1'b0;
      end else if (rx_cap) begin
         rx_data <= rx_pipe[LAST][15:0];
         rx_k_hi <= rx_pipe[LAST][17];
         rx_k_lo <= prbs_enable ? item_a : rx_pipe[LAST][16];
      end
   end

   // apb slave, zero wait states, registered answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !reg_mapped(paddr);
         if (psel && !penable && !pwrite && paddr == `SCD_REG_CTRL)
            prdata <= 32'({prbs_enable});
         else if (psel && !penable && !pwrite && paddr == `SCD_REG_STAT)
            prdata <= 32'({dec_err_st, prbs_err_st, los, aligned});
         else if (psel && !penable)
            prdata <= '0;
      end
   end

   // sticky errors: hardware set beats software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prbs_enable <= 1'b0;
         prbs_err_st <= 1'b0;
         dec_err_st <= 1'b0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == `SCD_REG_CTRL)
            prbs_enable <= pwdata[`SCD_CTRL_PRBS];
         if (prbs_enable && rx_cap && !item_a) prbs_err_st <= 1'b1;
         else if (psel && penable && pready && pwrite && paddr == `SCD_REG_STAT
                  && pwdata[`SCD_STAT_PRBS_ERR]) prbs_err_st <= 1'b0;
         if (!prbs_enable && rx_cap && !los && |dec_err) dec_err_st <= 1'b1;
         else if (psel && penable && pready && pwrite && paddr == `SCD_REG_STAT
                  && pwdata[`SCD_STAT_DEC_ERR]) dec_err_st <= 1'b0;
      end
   end

   sequence s_lo_first;
      (serial_out_p == $past(tx_word[0])) ##1 (serial_out_p == $past(tx_word[1], 2));
   endsequence
   sequence s_hi_after;
      ##9 (serial_out_p == $past(tx_word[10], 11));
   endsequence
   property p_ser_order;
      // the release edge still runs the reset branch, so no attempt starts there
      @(posedge pclk) disable iff (!presetn) presetn && tx_ld |=> s_lo_first ##0 s_hi_after;
   endproperty
   a_ser_order: assert property (p_ser_order) else $error("serial bit order wrong");

   property p_tx_cap;
      @(posedge pclk) disable iff (!presetn)
         $rose(tx_word_clock) |-> tx_q == $past(tx_data) && tx_kq == $past({tx_k_hi, tx_k_lo});
   endproperty
   a_tx_cap: assert property (p_tx_cap) else $error("tx word not captured");

   property p_prbs_tx;
      @(posedge pclk) disable iff (!presetn)
         tx_ld && prbs_enable |=> serial_out_p == $past(prbs_word[0]) ##1 serial_out_p == $past(prbs_word[1], 2);
   endproperty
   a_prbs_tx: assert property (p_prbs_tx) else $error("prbs not sent");

   property p_comma;
      @(posedge pclk) disable iff (!presetn) comma |=> rx_phase == '0 && aligned ##1 rx_phase == 5'h01;
   endproperty
   a_comma: assert property (p_comma) else $error("comma did not align");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
         presetn && !comma && rx_phase != `SCD_PHASE_LAST |=> rx_phase == $past(rx_phase) + 5'h01;
   endproperty
   a_hold: assert property (p_hold) else $error("alignment moved without comma");

   property p_los;
      @(posedge pclk) disable iff (!presetn)
         rx_cap && los |=> rx_pipe[0] == {2'b11, `SCD_K_LOS, `SCD_K_LOS};
   endproperty
   a_los: assert property (p_los) else $error("lost signal not flagged");

   property p_err;
      @(posedge pclk) disable iff (!presetn)
         rx_cap && !los && dec_err[0] && !dec_err[1]
         |=> rx_pipe[0][7:0] == `SCD_K_ERR && rx_pipe[0][16] && rx_pipe[0][15:8] == $past(dec_byte[1]);
   endproperty
   a_err: assert property (p_err) else $error("decode error not isolated");

   property p_kvalid;
      @(posedge pclk) disable iff (!presetn)
         dec_k[0] && !dec_err[0]
         |-> dec_byte[0][4:0] == 5'h1C || dec_byte[0] inside {8'hF7, 8'hFB, 8'hFD, 8'hFE};
   endproperty
   a_kvalid: assert property (p_kvalid) else $error("unlisted control accepted");

   property p_wclk;
      @(posedge pclk) disable iff (!presetn) $rose(rx_word_clock) |-> rx_phase == `SCD_PHASE_HALF;
   endproperty
   a_wclk: assert property (p_wclk) else $error("word clock phase wrong");

   property p_pass;
      @(posedge pclk) disable iff (!presetn) prbs_enable && rx_cap && !item_a |=> !rx_k_lo;
   endproperty
   a_pass: assert property (p_pass) else $error("prbs error not shown");

   property p_apb;
      @(posedge pclk) disable iff (!presetn) psel && !penable |=> pready ##1 !pready || psel;
   endproperty
   a_apb: assert property (p_apb) else $error("apb ready late");
endmodule // scd_datapath

// ===== scd_far_end.sv
// far-end transceiver model: returns the serial line to the device one bit later
// assumes the line bits are synchronous to pclk; can drop or corrupt the line
`timescale 1ns/1ps
module scd_far_end (
   input wire logic pclk, // bit clock
   input wire logic line_p, // serial from the device, true
   input wire logic line_n, // serial from the device, complement
   input wire logic drop, // lose the signal
   input wire logic flip, // corrupt the current bit
   output logic ret_p, // serial to the device, true
   output logic ret_n // serial to the device, complement
);
   logic wob = 1'b0;
   always @(posedge pclk) begin
      wob <= ~wob;
      // a dropped line toggles so a stale level never passes for data
      ret_p <= drop ? wob : line_p ^ flip;
      ret_n <= drop ? wob : line_n ^ flip;
   end
endmodule // scd_far_end

// ===== scd_datapath_tb_top.sv
// bench of the serdes datapath: apb tasks, serial loopback, received word checks
// assumes the far-end model loops the serial line back to the receiver
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module scd_datapath_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, txwc, so_p, so_n, si_p, si_n, rx_k_lo, rx_k_hi, rxwc;
   logic tx_k_lo = 1'b0;
   logic tx_k_hi = 1'b0;
   logic [15:0] tx_data = 16'h0000;
   logic [15:0] rx_data;
   logic drop = 1'b0;
   logic flip = 1'b0;
   logic chk_on = 1'b0;
   logic synced = 1'b0;
   logic low_seen;
   logic [17:0] exp_w;
   logic [17:0] q[$];
   logic [7:0] ktab[12] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC, 8'hFC,
      8'hF7, 8'hFB, 8'hFD, 8'hFE};
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   int wi = 0;

   always #12.5 pclk = ~pclk;

   scd_datapath #(.LOS_BITS(8'h02)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_k_lo(tx_k_lo),
      .tx_k_hi(tx_k_hi), .tx_word_clock(txwc), .serial_out_p(so_p), .serial_out_n(so_n),
      .serial_in_p(si_p), .serial_in_n(si_n), .rx_data(rx_data), .rx_k_lo(rx_k_lo),
      .rx_k_hi(rx_k_hi), .rx_word_clock(rxwc));

   scd_far_end u_far (.pclk(pclk), .line_p(so_p), .line_n(so_n), .drop(drop), .flip(flip),
      .ret_p(si_p), .ret_n(si_n));

   // next word right after its capture edge
   always @(posedge txwc) begin
      q.push_back({tx_k_hi, tx_k_lo, tx_data});
      wi <= wi + 1;
      tx_k_lo <= (wi % 4 == 0) || (wi % 4 == 2);
      tx_k_hi <= (wi % 4 == 0);
      // comma-bearing codes stay in the low byte so the boundary never moves
      tx_data <= (wi % 4 == 0) ? 16'h1CBC : (wi % 4 == 2) ? {8'h4A, ktab[(wi / 4) % 12]}
         : {wi[7:0], ~wi[7:0]};
   end

   always @(posedge rxwc) begin
      if (chk_on && !synced && rx_k_lo === 1'b1 && rx_data[7:0] === 8'hBC) begin
         while (q.size() > 0 && q[0] !== {rx_k_hi, rx_k_lo, rx_data}) void'(q.pop_front());
         synced = 1'b1;
      end
      if (chk_on && synced) begin
         exp_w = q.pop_front();
         `CHK("rx word", exp_w, {rx_k_hi, rx_k_lo, rx_data})
      end
   end

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed: pready ends this wait, or else only the bench timeout
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic words(input int n);
      repeat (n) @(posedge rxwc);
      @(negedge pclk);
   endtask

   task automatic end_of_test;
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test;
      end
   end

   initial begin
      repeat (6) @(posedge pclk);
      `CHK("rx clock in reset", 1'b0, rxwc)
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0000_0000);
      `CHK("ctrl reset", 32'h0000_0000, rd)
      apb(1'b0, 12'h008, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0000_0000, rd)
      apb(1'b1, 12'h000, 32'h0000_0001);
      apb(1'b0, 12'h000, 32'h0000_0000);
      `CHK("ctrl rw", 32'h0000_0001, rd)
      apb(1'b1, 12'h000, 32'h0000_0000);
      $display("test regs done");
      chk_on = 1'b1;
      words(60);
      chk_on = 1'b0;
      `CHK("synced", 1'b1, synced)
      apb(1'b0, 12'h004, 32'h0000_0000);
      `CHK("aligned", 1'b1, rd[0])
      $display("test data done");
      drop <= 1'b1;
      // loss must pass the three-word pipe before it shows
      words(6);
      `CHK("los word", 18'h3_FFFF, {rx_k_hi, rx_k_lo, rx_data})
      apb(1'b0, 12'h004, 32'h0000_0000);
      `CHK("los stat", 1'b1, rd[1])
      drop <= 1'b0;
      $display("test los done");
      apb(1'b1, 12'h000, 32'h0000_0001);
      words(10);
      apb(1'b1, 12'h004, 32'h0000_000C);
      words(4);
      `CHK("item_a", 1'b1, rx_k_lo)
      apb(1'b0, 12'h004, 32'h0000_0000);
      `CHK("prbs clean", 1'b0, rd[2])
      @(posedge pclk);
      flip <= 1'b1;
      @(posedge pclk);
      flip <= 1'b0;
      low_seen = 1'b0;
      repeat (4) begin
         @(posedge rxwc);
         if (rx_k_lo === 1'b0) low_seen = 1'b1;
      end
      `CHK("prbs fail seen", 1'b1, low_seen)
      apb(1'b0, 12'h004, 32'h0000_0000);
      `CHK("prbs err stat", 1'b1, rd[2])
      $display("test prbs done");
      end_of_test;
   end
endmodule // scd_datapath_tb_top
